// >>> ssrg_pkg.sv
package ssrg_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STRAP_OFS = 8'h04;
  localparam logic [7:0] FUNC_OFS = 8'h08;
  localparam logic [7:0] DIR_OFS = 8'h0C;
  localparam logic [7:0] DOUT_OFS = 8'h10;
  localparam logic [7:0] DIN_OFS = 8'h14;
  localparam logic [7:0] FOEN_OFS = 8'h18;
  localparam logic [7:0] FOST_OFS = 8'h1C;
  // field positions
  localparam int HALT_BIT = 0;
  localparam int STRAP_MODE_LSB = 0;
  localparam int STRAP_STK2_LSB = 4;
  localparam int STRAP_STK3_LSB = 9;
  localparam int STRAP_CLK_LSB = 14;
  localparam int STRAP_FSEL_BIT = 16;
  // reset values
  localparam logic [17:0] FUNC_RST = 18'h0_0000;
  localparam logic [8:0] DIR_RST = 9'h000;
  localparam logic [8:0] DOUT_RST = 9'h000;
  localparam logic [3:0] FOEN_RST = 4'h0;
  // pin count and pin function codes
  localparam int NPIN = 9;
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  // pins whose alternate functions drive the pin
  localparam logic [8:0] ALT1_OUT = 9'h020;
  localparam logic [8:0] ALT2_OUT = 9'h1B0;
  // reference clock frequencies in mhz
  localparam logic [7:0] REFCLK_SEL0_MHZ = 8'h64;
  localparam logic [7:0] REFCLK_SEL1_MHZ = 8'h7D;
  // switch mode codes
  localparam logic [3:0] MODE_SP = 4'h0;
  localparam logic [3:0] MODE_SP_EE = 4'h1;
  localparam logic [3:0] MODE_SP_J0 = 4'h2;
  localparam logic [3:0] MODE_SP_J1 = 4'h3;
  localparam logic [3:0] MODE_SP_LL = 4'h8;
  localparam logic [3:0] MODE_SP_EE_LL = 4'h9;
  localparam logic [3:0] MODE_MP_U = 4'hA;
  localparam logic [3:0] MODE_MP_U_I2C = 4'hB;
  localparam logic [3:0] MODE_MP_U_EE = 4'hC;
  localparam logic [3:0] MODE_MP_U_BOTH = 4'hD;
  localparam logic [3:0] MODE_MP_D0 = 4'hE;
  localparam logic [3:0] MODE_MP_D1 = 4'hF;
  // bring-up sequence states
  typedef enum logic [2:0] {
    SSRG_SAMPLE = 3'b001,
    SSRG_HALT = 3'b010,
    SSRG_RUN = 3'b100
  } ssrg_state_t;
endpackage

// >>> ssrg_top.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
module ssrg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] switch_mode_strap,
  input wire logic [4:0] stack2_config_strap,
  input wire logic [4:0] stack3_config_strap,
  input wire logic [1:0] port_clocking_strap,
  input wire logic refclk_freq_select,
  input wire logic reset_hold_request,
  input wire logic port0_link_up,
  input wire logic port0_link_active,
  input wire logic port8_link_up,
  input wire logic port8_link_active,
  input wire logic hotplug_event,
  input wire logic [8:0] gpio_in,
  output logic [8:0] gpio_out,
  output logic [8:0] gpio_oe_n,
  output logic [3:0] failover_event,
  output logic [3:0] partition_reset,
  output logic expander_irq,
  output logic core_run,
  output logic quasi_reset,
  output logic smbus_active,
  output logic [7:0] refclk_freq_mhz,
  output logic [1:0] clock_mode,
  output logic multi_partition,
  output logic eeprom_init,
  output logic eeprom_jump0,
  output logic eeprom_jump1,
  output logic reduced_latency,
  output logic i2c_reset,
  output logic unattached_ports,
  output logic disabled_ports,
  output logic mode_reserved
);

  ssrg_pkg::ssrg_state_t state_reg; // bring-up sequence
  logic halt_reg; // halt bit of switch control
  logic [16:0] strap_reg; // captured strap word
  logic [17:0] func_reg; // two function bits per pin
  logic [8:0] dir_reg; // gpio direction, 1 drives
  logic [8:0] dout_reg; // gpio output data
  logic [3:0] foen_reg; // failover enables
  logic [3:0] fost_reg; // sticky failover events
  logic [3:0] trig_prev_reg; // last seen trigger levels
  logic [3:0] trig_cur; // trigger levels this cycle
  logic [3:0] trig_sel; // trigger routed to a pin
  logic [3:0] fo_hit; // qualified trigger change
  logic [8:0] alt1_val; // alt1 output level per pin
  logic [8:0] alt2_val; // alt2 output level per pin
  logic [31:0] rd_next; // read mux result
  logic hit; // address maps to a register
  logic wr_acc; // write access phase
  logic [3:0] mode_c; // mode code shorthand

  // zero-wait slave; every transfer finishes in one access cycle
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  // management path stays alive in every state, quasi-reset included
  assign smbus_active = 1'b1;
  assign mode_c = strap_reg[ssrg_pkg::STRAP_MODE_LSB +: 4];

  // bring-up: capture straps, then halt or run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ssrg_pkg::SSRG_SAMPLE;
    end else begin
      case (state_reg)
        ssrg_pkg::SSRG_SAMPLE: begin
          // hold request at release parks the switch
          if (reset_hold_request) begin
            state_reg <= ssrg_pkg::SSRG_HALT;
          end else begin
            state_reg <= ssrg_pkg::SSRG_RUN;
          end
        end
        ssrg_pkg::SSRG_HALT: begin
          // only software clearing the halt bit releases it
          if (!halt_reg) begin
            state_reg <= ssrg_pkg::SSRG_RUN;
          end
        end
        ssrg_pkg::SSRG_RUN: begin
          state_reg <= ssrg_pkg::SSRG_RUN;
        end
        default: begin
          state_reg <= ssrg_pkg::SSRG_SAMPLE;
        end
      endcase
    end
  end

  // halt bit: loaded from the request, cleared by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reg <= 1'b0;
    end else if (state_reg == ssrg_pkg::SSRG_SAMPLE) begin
      halt_reg <= reset_hold_request;
    end else if (wr_acc && paddr == ssrg_pkg::CTRL_OFS) begin
      halt_reg <= pwdata[ssrg_pkg::HALT_BIT];
    end
  end

  assign core_run = (state_reg == ssrg_pkg::SSRG_RUN);
  assign quasi_reset = (state_reg == ssrg_pkg::SSRG_HALT);

  // straps caught once at the first edge after release; later
  // changes are ignored because the board must hold them anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_reg <= 17'h0_0000;
    end else if (state_reg == ssrg_pkg::SSRG_SAMPLE) begin
      strap_reg <= {refclk_freq_select, port_clocking_strap,
        stack3_config_strap, stack2_config_strap,
        switch_mode_strap};
    end
  end

  // static configuration outputs from the captured straps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_mode <= 2'h0;
      refclk_freq_mhz <= ssrg_pkg::REFCLK_SEL0_MHZ;
    end else begin
      clock_mode <= strap_reg[ssrg_pkg::STRAP_CLK_LSB +: 2];
      if (strap_reg[ssrg_pkg::STRAP_FSEL_BIT]) begin
        refclk_freq_mhz <= ssrg_pkg::REFCLK_SEL1_MHZ;
      end else begin
        refclk_freq_mhz <= ssrg_pkg::REFCLK_SEL0_MHZ;
      end
    end
  end

  // switch mode decode into feature flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {multi_partition, eeprom_init, eeprom_jump0, eeprom_jump1,
        reduced_latency, i2c_reset, unattached_ports,
        disabled_ports, mode_reserved} <= 9'h000;
    end else begin
      {multi_partition, eeprom_init, eeprom_jump0, eeprom_jump1,
        reduced_latency, i2c_reset, unattached_ports,
        disabled_ports, mode_reserved} <= 9'h000;
      case (mode_c)
        ssrg_pkg::MODE_SP: begin
          multi_partition <= 1'b0;
        end
        ssrg_pkg::MODE_SP_EE: begin
          eeprom_init <= 1'b1;
        end
        ssrg_pkg::MODE_SP_J0: begin
          eeprom_jump0 <= 1'b1;
        end
        ssrg_pkg::MODE_SP_J1: begin
          eeprom_jump1 <= 1'b1;
        end
        ssrg_pkg::MODE_SP_LL: begin
          reduced_latency <= 1'b1;
        end
        ssrg_pkg::MODE_SP_EE_LL: begin
          reduced_latency <= 1'b1;
          eeprom_init <= 1'b1;
        end
        ssrg_pkg::MODE_MP_U: begin
          multi_partition <= 1'b1;
          unattached_ports <= 1'b1;
        end
        ssrg_pkg::MODE_MP_U_I2C: begin
          multi_partition <= 1'b1;
          unattached_ports <= 1'b1;
          i2c_reset <= 1'b1;
        end
        ssrg_pkg::MODE_MP_U_EE: begin
          multi_partition <= 1'b1;
          unattached_ports <= 1'b1;
          eeprom_init <= 1'b1;
        end
        ssrg_pkg::MODE_MP_U_BOTH: begin
          multi_partition <= 1'b1;
          unattached_ports <= 1'b1;
          i2c_reset <= 1'b1;
          eeprom_init <= 1'b1;
        end
        ssrg_pkg::MODE_MP_D0, ssrg_pkg::MODE_MP_D1: begin
          multi_partition <= 1'b1;
          disabled_ports <= 1'b1;
        end
        default: begin
          mode_reserved <= 1'b1;
        end
      endcase
    end
  end

  // alternate output levels, status inverted onto low-true pins
  always_comb begin
    alt1_val = '1;
    alt2_val = '1;
    alt1_val[5] = ~hotplug_event;
    alt2_val[4] = ~port0_link_up;
    alt2_val[5] = ~port0_link_active;
    alt2_val[7] = ~port8_link_up;
    alt2_val[8] = ~port8_link_active;
  end

  // per-pin mux; undefined function codes fall back to gpio
  genvar gi;
  generate
    for (gi = 0; gi < ssrg_pkg::NPIN; gi++) begin : g_pin
      logic [1:0] fn;
      assign fn = func_reg[2*gi +: 2];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gpio_out[gi] <= 1'b1;
          gpio_oe_n[gi] <= 1'b1;
        end else if (fn == ssrg_pkg::FN_ALT1) begin
          gpio_out[gi] <= alt1_val[gi];
          gpio_oe_n[gi] <= ~ssrg_pkg::ALT1_OUT[gi];
        end else if (fn == ssrg_pkg::FN_ALT2) begin
          gpio_out[gi] <= alt2_val[gi];
          gpio_oe_n[gi] <= ~ssrg_pkg::ALT2_OUT[gi];
        end else begin
          gpio_out[gi] <= dout_reg[gi];
          gpio_oe_n[gi] <= ~dir_reg[gi];
        end
      end
    end
  endgenerate

  // partition resets and expander interrupt, low at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partition_reset <= 4'h0;
      expander_irq <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        partition_reset[i] <= (func_reg[2*i +: 2] == ssrg_pkg::FN_ALT1)
          & ~gpio_in[i];
      end
      expander_irq <= (func_reg[17:16] == ssrg_pkg::FN_ALT1)
        & ~gpio_in[8];
    end
  end

  // failover trigger routing; history always tracks the raw pin,
  // so routing or enabling a trigger never fires on a stale level
  always_comb begin
    trig_sel[0] = (func_reg[9:8] == ssrg_pkg::FN_ALT1);
    trig_sel[1] = (func_reg[13:12] == ssrg_pkg::FN_ALT1);
    trig_sel[2] = (func_reg[15:14] == ssrg_pkg::FN_ALT1);
    trig_sel[3] = (func_reg[13:12] == ssrg_pkg::FN_ALT2);
    trig_cur[0] = gpio_in[4];
    trig_cur[1] = gpio_in[6];
    trig_cur[2] = gpio_in[7];
    trig_cur[3] = gpio_in[6];
    fo_hit = (trig_cur ^ trig_prev_reg) & trig_sel & foen_reg;
  end

  // trigger history plus one-cycle event strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg <= 4'h0;
      failover_event <= 4'h0;
    end else begin
      // history follows the pin even when disabled, so enabling
      // later does not fire on an old change
      trig_prev_reg <= trig_cur;
      failover_event <= fo_hit;
    end
  end

  // sticky failover status, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fost_reg <= 4'h0;
    end else if (wr_acc && paddr == ssrg_pkg::FOST_OFS) begin
      fost_reg <= (fost_reg & ~pwdata[3:0]) | fo_hit;
    end else begin
      fost_reg <= fost_reg | fo_hit;
    end
  end

  // writable configuration, usable in quasi-reset as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reg <= ssrg_pkg::FUNC_RST;
      dir_reg <= ssrg_pkg::DIR_RST;
      dout_reg <= ssrg_pkg::DOUT_RST;
      foen_reg <= ssrg_pkg::FOEN_RST;
    end else if (wr_acc) begin
      case (paddr)
        ssrg_pkg::FUNC_OFS: begin
          func_reg <= pwdata[17:0];
        end
        ssrg_pkg::DIR_OFS: begin
          dir_reg <= pwdata[8:0];
        end
        ssrg_pkg::DOUT_OFS: begin
          dout_reg <= pwdata[8:0];
        end
        ssrg_pkg::FOEN_OFS: begin
          foen_reg <= pwdata[3:0];
        end
        default: begin
          foen_reg <= foen_reg;
        end
      endcase
    end
  end

  // read mux; unmapped offsets answer zero with an error
  always_comb begin
    rd_next = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      ssrg_pkg::CTRL_OFS: rd_next[ssrg_pkg::HALT_BIT] = halt_reg;
      ssrg_pkg::STRAP_OFS: rd_next[16:0] = strap_reg;
      ssrg_pkg::FUNC_OFS: rd_next[17:0] = func_reg;
      ssrg_pkg::DIR_OFS: rd_next[8:0] = dir_reg;
      ssrg_pkg::DOUT_OFS: rd_next[8:0] = dout_reg;
      ssrg_pkg::DIN_OFS: rd_next[8:0] = gpio_in;
      ssrg_pkg::FOEN_OFS: rd_next[3:0] = foen_reg;
      ssrg_pkg::FOST_OFS: rd_next[3:0] = fost_reg;
      default: hit = 1'b0;
    endcase
  end

  // answer registered in the setup cycle, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_next;
      pslverr <= ~hit;
    end
  end

endmodule // ssrg_top

// >>> ssrg_board.sv
`timescale 1ns/10ps
// board control logic: straps, hold request and the pin levels it drives
module ssrg_board (
  input wire logic presetn,
  input wire logic [17:0] strap_want,
  input wire logic [8:0] pin_drive,
  input wire logic [8:0] gpio_out,
  input wire logic [8:0] gpio_oe_n,
  output logic [17:0] strap_bus,
  output logic [8:0] gpio_in
);
  // straps follow the wish only while reset is low, then stay frozen
  always_latch begin
    if (!presetn) begin
      strap_bus <= strap_want;
    end
  end

  // resolved pin: the device level where it drives, else the board level
  assign gpio_in = (gpio_oe_n & pin_drive) | (~gpio_oe_n & gpio_out);
endmodule // ssrg_board

// >>> ssrg_top_chk.sv
`timescale 1ns/10ps
// port checker; the frequency check needs straps frozen after release
module ssrg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic refclk_freq_select,
  input wire logic [8:0] gpio_in,
  input wire logic [3:0] failover_event,
  input wire logic [3:0] partition_reset,
  input wire logic expander_irq,
  input wire logic core_run,
  input wire logic quasi_reset,
  input wire logic smbus_active,
  input wire logic [7:0] refclk_freq_mhz,
  input wire logic [1:0] clock_mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access phase that clears the halt bit
  wire logic clr_halt = psel & penable & pwrite & (paddr == ssrg_pkg::CTRL_OFS)
    & ~pwdata[ssrg_pkg::HALT_BIT];
  // core either parked or running, never both
  wire logic live = core_run | quasi_reset;

  AST_MGMT: assert property (smbus_active)
    else $error("management bus not active");
  AST_ONE_STATE: assert property (!(core_run && quasi_reset))
    else $error("run and quasi-reset together");
  AST_HOLD: assert property (quasi_reset && !clr_halt && !$past(clr_halt) |=> quasi_reset)
    else $error("quasi-reset left without a halt clear");
  AST_EXIT: assert property (quasi_reset && clr_halt |-> ##[1:2] core_run)
    else $error("halt clear did not start the core");
  AST_RUN: assert property (core_run |=> core_run)
    else $error("core left run state");
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("register access not answered");
  AST_FREQ: assert property (live && $past(live, 2) |->
    refclk_freq_mhz == (refclk_freq_select ? 8'h7D : 8'h64))
    else $error("reference frequency does not match select");
  AST_MODE_HELD: assert property (live && $past(live, 2) |-> $stable(clock_mode))
    else $error("clock mode changed after capture");
  AST_FO0: assert property ($rose(failover_event[0]) |->
    $past(gpio_in[4]) != $past(gpio_in[4], 2))
    else $error("trigger 0 event without pin change");
  AST_IRQ: assert property (expander_irq |-> !$past(gpio_in[8]))
    else $error("expander interrupt with pin high");
  AST_PART: assert property ((partition_reset & $past(gpio_in[3:0])) == 4'h0)
    else $error("partition reset with pin high");
endmodule // ssrg_chk

bind ssrg_top ssrg_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .refclk_freq_select(refclk_freq_select),
  .gpio_in(gpio_in), .failover_event(failover_event), .partition_reset(partition_reset),
  .expander_irq(expander_irq), .core_run(core_run), .quasi_reset(quasi_reset),
  .smbus_active(smbus_active), .refclk_freq_mhz(refclk_freq_mhz), .clock_mode(clock_mode)
);

// >>> tb_ssrg_top.sv
`timescale 1ns/10ps
// bench for the strap, reset-hold and pin-mux block
module tb_ssrg_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, freq;
  logic [31:0] pwdata, prdata, rdv; // rdv: data taken at the access edge
  logic [17:0] want, sb; // strap wish and frozen board straps
  logic [8:0] drv, gin, gout, goe_n, fl; // fl: mode flags, multi first
  logic [3:0] foe, prst;
  logic [1:0] cmode;
  logic up0, act0, up8, act8, hp, irq, run, qrst, smb;
  int n_errors = 0;
  int n_tests = 0;

  ssrg_top i_ssrg_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_mode_strap(sb[3:0]), .stack2_config_strap(sb[8:4]),
    .stack3_config_strap(sb[13:9]), .port_clocking_strap(sb[15:14]),
    .refclk_freq_select(sb[16]), .reset_hold_request(sb[17]),
    .port0_link_up(up0), .port0_link_active(act0), .port8_link_up(up8),
    .port8_link_active(act8), .hotplug_event(hp), .gpio_in(gin), .gpio_out(gout),
    .gpio_oe_n(goe_n), .failover_event(foe), .partition_reset(prst), .expander_irq(irq),
    .core_run(run), .quasi_reset(qrst), .smbus_active(smb), .refclk_freq_mhz(freq),
    .clock_mode(cmode), .multi_partition(fl[8]), .eeprom_init(fl[7]),
    .eeprom_jump0(fl[6]), .eeprom_jump1(fl[5]), .reduced_latency(fl[4]),
    .i2c_reset(fl[3]), .unattached_ports(fl[2]), .disabled_ports(fl[1]),
    .mode_reserved(fl[0])
  );
  ssrg_board i_ssrg_board (
    .presetn(presetn), .strap_want(want), .pin_drive(drv), .gpio_out(gout),
    .gpio_oe_n(goe_n), .strap_bus(sb), .gpio_in(gin)
  );

  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // single exit of the run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdv = prdata;
    if (pready !== 1'b1) begin
      n_errors++; // a hung slave ends the run
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // reset with a mode code; frequency select follows bit 0 of the code
  task automatic rst(input logic [3:0] m, input logic h);
    @(posedge pclk);
    presetn <= 1'b0;
    want <= {h, m[0], 2'h2, 5'h0A, 5'h15, m};
    tick(3);
    @(posedge pclk);
    presetn <= 1'b1;
    tick(3);
  endtask

  // flip one board pin and look for the one-cycle event flag
  task automatic tog(input int p, input logic [3:0] e);
    @(posedge pclk);
    drv[p] <= ~drv[p];
    tick(1);
    chk(foe, e);
  endtask

  // expected flags {multi, ee, jump0, jump1, low lat, i2c, unatt, disabled, reserved}
  function automatic logic [8:0] expf(input logic [3:0] m);
    case (m)
      4'h0: expf = 9'h000;
      4'h1: expf = 9'h080;
      4'h2: expf = 9'h040;
      4'h3: expf = 9'h020;
      4'h8: expf = 9'h010;
      4'h9: expf = 9'h090;
      4'hA: expf = 9'h104;
      4'hB: expf = 9'h10C;
      4'hC: expf = 9'h184;
      4'hD: expf = 9'h18C;
      4'hE, 4'hF: expf = 9'h102;
      default: expf = 9'h001; // codes 4 to 7
    endcase
  endfunction

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    want = 18'h0_0000;
    drv = 9'h1FF; // board idles every pin high
    {up0, act0, up8, act8, hp} = 5'h00;
    // hold request: registers reachable while the core is parked
    rst(4'hC, 1'b1);
    chk({qrst, run, smb}, 3'h5);
    rd(ssrg_pkg::STRAP_OFS, {15'h0, 1'b0, 2'h2, 5'h0A, 5'h15, 4'hC});
    chk(cmode, 2'h2);
    wr(ssrg_pkg::FUNC_OFS, 32'h0000_1234);
    rd(ssrg_pkg::FUNC_OFS, 32'h0000_1234);
    rd(8'h20, 32'h0000_0000);
    chk(pslverr, 1'b1);
    chk(run, 1'b0);
    wr(ssrg_pkg::CTRL_OFS, 32'h0000_0000);
    tick(2);
    chk({qrst, run}, 2'h1);
    $display("test halt done");
    // every mode code, each entered through a fresh reset
    for (int m = 0; m < 16; m++) begin
      rst(4'(m), 1'b0);
      chk(fl, expf(4'(m)));
      chk(freq, m[0] ? 8'h7D : 8'h64);
      chk(run, 1'b1);
    end
    rd(ssrg_pkg::FUNC_OFS, 32'h0000_0000);
    $display("test modes done");
    // plain pins: two outputs, one board-driven input
    wr(ssrg_pkg::DIR_OFS, 32'h0000_0003);
    wr(ssrg_pkg::DOUT_OFS, 32'h0000_0001);
    drv[2] <= 1'b0;
    rd(ssrg_pkg::DIN_OFS, 32'h0000_01F9);
    chk(goe_n[1:0], 2'h0);
    wr(ssrg_pkg::DIR_OFS, 32'h0000_0000);
    $display("test plain pins done");
    // status outputs, inverted onto the pins
    {up0, act0, up8, act8, hp} <= 5'h13;
    wr(ssrg_pkg::FUNC_OFS, 32'h0002_8600);
    tick(2);
    chk({goe_n & 9'h1F0, gout & 9'h1B0}, {9'h040, 9'h080});
    {up0, act0, up8, act8, hp} <= 5'h0C;
    wr(ssrg_pkg::FUNC_OFS, 32'h0002_8A00);
    tick(2);
    chk(gout & 9'h1B0, 9'h110);
    $display("test status pins done");
    // input alternates; routing is done before enabling so no stray event
    drv[8] <= 1'b0;
    wr(ssrg_pkg::FUNC_OFS, 32'h0001_6155);
    wr(ssrg_pkg::FOEN_OFS, 32'h0000_000B);
    wr(ssrg_pkg::FOST_OFS, 32'h0000_000F);
    tick(1);
    chk({irq, prst}, 5'h14);
    tog(4, 4'h1);
    tog(6, 4'h8);
    tog(7, 4'h0);
    rd(ssrg_pkg::FOST_OFS, 32'h0000_0009);
    wr(ssrg_pkg::FOST_OFS, 32'h0000_0009);
    rd(ssrg_pkg::FOST_OFS, 32'h0000_0000);
    $display("test failover done");
    complete_run();
  end
endmodule // tb_ssrg_top
